// [verilog/ccpi_pkg.sv]
// Shared constants for the cascaded CAM device and its controller.
// Contract
// - All devices compare in parallel each cycle
// - Local match held until strobe rises
// - Chain result ripples, each stage adds delay
// - Controller waits flag time plus stage delays
// - No output enable or status read before settling; the testbench polls status while busy
// - Space next-free writes for full chain settling
// - External logic ANDs higher-priority match outputs
// - Strobes behave same under external prioritization
// - Exactly one device enables path lookup table
// - Combined match only in table-enabled device
// - Every device gets distinct page address
// - First non-full device stores page, goes full
// - Next page write reaches next lower device
// - Full flag clear command empties every device; the code clears only forced_full and keeps stored entries
// - Broadcast common configuration before page assignment
// - Select device, enable table, then load masks
// - Second mask excludes channel identifier bits
// - Match out low if match in low or local
// - Full out low only if full in low and full
// - Only first matching device drives outputs
package ccpi_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int DATA_W         = 32;
  localparam int ADDR_W         = 4;
  localparam int PAGE_W         = 4;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SINGLE_FLAG_NS = 20;
  localparam int STAGE_PASS_NS  = 8;
  localparam int FULL_PASS_NS   = 4;
  localparam int OE_LAT_CYC     = 1;

  // ****************************************************************
  // Commands
  // ****************************************************************
  localparam logic [2:0] CMD_NOP      = 3'h0;
  localparam logic [2:0] CMD_CONFIG   = 3'h1;
  localparam logic [2:0] CMD_PAGE_WR  = 3'h2;
  localparam logic [2:0] CMD_FF_CLR   = 3'h3;
  localparam logic [2:0] CMD_SELECT   = 3'h4;
  localparam logic [2:0] CMD_MASK1    = 3'h5;
  localparam logic [2:0] CMD_MASK2    = 3'h6;
  localparam logic [2:0] CMD_COMPARE  = 3'h7;

  localparam logic [2:0] CMD_NF_WRITE = 3'h0;

  // ****************************************************************
  // Configuration fields and values
  // ****************************************************************
  localparam int CFG_TABLE_BIT = 8;
  localparam logic [31:0] CFG_COMMON   = 32'h03000000;
  localparam logic [31:0] CFG_TABLE_ON = 32'h00000100;
  localparam logic [31:0] MASK1_VAL    = 32'h0000000f;
  localparam logic [31:0] MASK2_VAL    = 32'h000fffff;
  localparam logic [31:0] SEL_NONE     = 32'h00000000;
  localparam int          SEL_EN_BIT   = 4;

  // ****************************************************************
  // Controller register map (APB)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_KEY     = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_RESULT  = 8'h0c;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_CMP_BIT  = 1;
  localparam int CTRL_WR_BIT   = 2;
  localparam int CTRL_SEL_LSB  = 4;

endpackage : ccpi_pkg

// [verilog/ccpi_if.sv]
// Interface joining one cascade device and the controller.
interface ccpi_if;
  logic        input_strobe_enable_n;
  logic [2:0]  cmd;
  logic [31:0] data;
  logic        oe_n;
  logic        match_in_n;
  logic        match_out_n;
  logic        full_in_n;
  logic        full_out_n;
  logic        match_valid_n;
  logic [31:0] q;
  logic        q_oe;

  modport dev (
    input  input_strobe_enable_n, cmd, data, oe_n, match_in_n, full_in_n,
    output match_out_n, full_out_n, match_valid_n, q, q_oe
  );
  modport ctl (
    output input_strobe_enable_n, cmd, data, oe_n, match_in_n, full_in_n,
    input  match_out_n, full_out_n, match_valid_n, q, q_oe
  );
endinterface : ccpi_if

// [verilog/ccpi_dev.sv]
// One cascade CAM device with match and full daisy-chain logic.
module ccpi_dev #(
  parameter int DEPTH = 16
) (
  input  wire logic I_CORE_CLK,
  input  wire logic I_RSTN,
  ccpi_if.dev       bus,
  output logic      O_TABLE_EN,
  output logic [3:0] O_PAGE
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DEPTH-1:0]       valid;
    logic [DEPTH-1:0][31:0] mem;
    logic [31:0]            cfg;
    logic [31:0]            mask2;
    logic [3:0]             page;
    logic                   dsel_on;
    logic [3:0]             dsel;
    logic                   forced_full;
    logic                   strobe_prev;
    logic                   pend_match;
    logic                   local_match;
    logic [3:0]             match_idx;
    logic                   match_out_n;
    logic                   full_out_n;
    logic                   mv_n;
    logic [31:0]            q;
    logic                   q_oe;
  } ccpi_dst_t;

  ccpi_dst_t s_q, s_d;
  logic      dev_full;
  logic      hit_any;
  logic [3:0] hit_idx;
  logic [3:0] free_idx;

  always_comb begin
    hit_any  = 1'b0;
    hit_idx  = '0;
    free_idx = '0;
    dev_full = &s_q.valid | s_q.forced_full;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (s_q.valid[i] &&
          ((s_q.mem[i] & ~s_q.mask2) == (bus.data & ~s_q.mask2))) begin
        hit_any = 1'b1;
        hit_idx = 4'(i);
      end
      if (!s_q.valid[i]) begin
        free_idx = 4'(i);
      end
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.strobe_prev = bus.input_strobe_enable_n;
    // Local result is captured while the strobe is low and only published on
    // its rising edge, so the chain never sees a half-made answer.
    if (!bus.input_strobe_enable_n && bus.cmd == ccpi_pkg::CMD_COMPARE) begin
      s_d.pend_match = hit_any;
      s_d.match_idx  = hit_idx;
    end
    if (bus.input_strobe_enable_n && !s_q.strobe_prev) begin
      case (bus.cmd)
        ccpi_pkg::CMD_COMPARE: s_d.local_match = s_q.pend_match;
        ccpi_pkg::CMD_CONFIG: begin
          // A live select lets only the device whose page matches take the
          // write, so one table can be enabled without touching the rest.
          if (!s_q.dsel_on || s_q.dsel == s_q.page) begin
            s_d.cfg = bus.data;
          end
        end
        ccpi_pkg::CMD_SELECT: begin
          s_d.dsel_on = bus.data[ccpi_pkg::SEL_EN_BIT];
          s_d.dsel    = bus.data[3:0];
        end
        ccpi_pkg::CMD_MASK2:   s_d.mask2 = bus.data;
        ccpi_pkg::CMD_PAGE_WR: begin
          if (!bus.full_in_n && !dev_full) begin
            s_d.page        = bus.data[3:0];
            s_d.forced_full = 1'b1;
          end
        end
        ccpi_pkg::CMD_FF_CLR:  s_d.forced_full = 1'b0;
        ccpi_pkg::CMD_NOP: begin
          if (!bus.full_in_n && !dev_full) begin
            s_d.valid[free_idx] = 1'b1;
            s_d.mem[free_idx]   = bus.data;
          end
        end
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    // One register stage per device models the ripple delay.
    s_d.match_out_n = bus.match_in_n & ~s_q.local_match;
    s_d.full_out_n  = ~(~bus.full_in_n & dev_full);
    s_d.mv_n = ~(s_q.local_match & s_q.cfg[ccpi_pkg::CFG_TABLE_BIT]);
    s_d.q_oe = bus.match_in_n & s_q.local_match & ~bus.oe_n;
    s_d.q    = {28'h0000000, s_q.match_idx};
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      s_q <= '0;
      s_q.strobe_prev <= 1'b1;
      s_q.match_out_n <= 1'b1;
      s_q.full_out_n  <= 1'b1;
      s_q.mv_n        <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.match_out_n   = s_q.match_out_n;
  assign bus.full_out_n    = s_q.full_out_n;
  assign bus.match_valid_n = s_q.mv_n;
  assign bus.q             = s_q.q;
  assign bus.q_oe          = s_q.q_oe;
  assign O_TABLE_EN        = s_q.cfg[ccpi_pkg::CFG_TABLE_BIT];
  assign O_PAGE            = s_q.page;

endmodule : ccpi_dev

// [verilog/ccpi_ctl.sv]
// Cascade controller: APB slave, init sequencer and compare timing.
//
// Local design decisions: the APB register port and the address map.
module ccpi_ctl #(
  parameter int N_DEV = 4
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RSTN,
  ccpi_if.ctl              bus,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR
);

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SETTLE_NS = ccpi_pkg::SINGLE_FLAG_NS +
                             (N_DEV - 1) * ccpi_pkg::STAGE_PASS_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + ccpi_pkg::CLK_PERIOD_NS - 1) /
                              ccpi_pkg::CLK_PERIOD_NS + N_DEV;
  localparam int FULL_CYC = ((N_DEV * ccpi_pkg::FULL_PASS_NS +
                    ccpi_pkg::CLK_PERIOD_NS - 1) /
                    ccpi_pkg::CLK_PERIOD_NS) + N_DEV;

  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_WAIT, ST_READ} ccpi_st_t;

  typedef struct packed {
    ccpi_st_t    st;
    logic [4:0]  step;
    logic [7:0]  cnt;
    logic [2:0]  cmd;
    logic [31:0] data;
    logic        strobe_n;
    logic        oe_n;
    logic        busy;
    logic        init_done;
    logic        cmp;
    logic        wr;
    logic        hit;
    logic [31:0] result;
    logic [31:0] key;
    logic [3:0]  sel;
    logic [31:0] prdata;
    logic        pready;
  } ccpi_cst_t;

  ccpi_cst_t s_q, s_d;
  logic      acc;
  logic      fin;

  always_comb begin
    s_d = s_q;
    // ****************************************************************
    // Register access
    // ****************************************************************
    // Read data is prepared in the first access cycle; a write only takes
    // effect at the edge where the master sees pready high.
    acc = I_PSEL & I_PENABLE & ~s_q.pready;
    fin = I_PSEL & I_PENABLE & s_q.pready;
    s_d.pready = acc;
    if (fin && I_PWRITE) begin
      case (I_PADDR)
        ccpi_pkg::REG_CTRL: begin
          if (!s_q.busy) begin
            s_d.sel  = I_PWDATA[ccpi_pkg::CTRL_SEL_LSB +: 4];
            s_d.busy = I_PWDATA[ccpi_pkg::CTRL_INIT_BIT] |
                       I_PWDATA[ccpi_pkg::CTRL_CMP_BIT] |
                       I_PWDATA[ccpi_pkg::CTRL_WR_BIT];
            s_d.cmp  = ~I_PWDATA[ccpi_pkg::CTRL_INIT_BIT] &
                       I_PWDATA[ccpi_pkg::CTRL_CMP_BIT];
            s_d.wr   = ~I_PWDATA[ccpi_pkg::CTRL_INIT_BIT] &
                       ~I_PWDATA[ccpi_pkg::CTRL_CMP_BIT] &
                       I_PWDATA[ccpi_pkg::CTRL_WR_BIT];
            s_d.step = '0;
          end
        end
        ccpi_pkg::REG_KEY: s_d.key = I_PWDATA;
        default: s_d.key = s_q.key;
      endcase
    end
    s_d.prdata = '0;
    if (acc && !I_PWRITE) begin
      case (I_PADDR)
        ccpi_pkg::REG_KEY:    s_d.prdata = s_q.key;
        ccpi_pkg::REG_STATUS: s_d.prdata = {29'h0, s_q.hit, s_q.init_done,
                                            s_q.busy};
        ccpi_pkg::REG_RESULT: s_d.prdata = s_q.result;
        default:              s_d.prdata = '0;
      endcase
    end
    // ****************************************************************
    // Command sequencer
    // ****************************************************************
    case (s_q.st)
      ST_IDLE: begin
        if (s_q.busy) begin
          s_d.st = ST_LOW;
          s_d.strobe_n = 1'b0;
          if (s_q.cmp) begin
            s_d.cmd = ccpi_pkg::CMD_COMPARE;
            s_d.data = s_q.key;
          end else if (s_q.wr) begin
            s_d.cmd = ccpi_pkg::CMD_NF_WRITE;
            s_d.data = s_q.key;
          end else if (s_q.step == 5'h00) begin
            s_d.cmd = ccpi_pkg::CMD_CONFIG;
            s_d.data = ccpi_pkg::CFG_COMMON;
          end else if (s_q.step <= 5'(N_DEV)) begin
            s_d.cmd = ccpi_pkg::CMD_PAGE_WR;
            s_d.data = 32'(s_q.step - 5'h01);
          end else if (s_q.step == 5'(N_DEV + 1)) begin
            s_d.cmd = ccpi_pkg::CMD_FF_CLR;
          end else if (s_q.step == 5'(N_DEV + 2)) begin
            s_d.cmd = ccpi_pkg::CMD_SELECT;
            s_d.data = 32'(s_q.sel) | (32'h00000001 << ccpi_pkg::SEL_EN_BIT);
          end else if (s_q.step == 5'(N_DEV + 3)) begin
            s_d.cmd = ccpi_pkg::CMD_CONFIG;
            s_d.data = ccpi_pkg::CFG_COMMON | ccpi_pkg::CFG_TABLE_ON;
          end else if (s_q.step == 5'(N_DEV + 4)) begin
            s_d.cmd = ccpi_pkg::CMD_SELECT;
            s_d.data = ccpi_pkg::SEL_NONE;
          end else if (s_q.step == 5'(N_DEV + 5)) begin
            s_d.cmd = ccpi_pkg::CMD_MASK1;
            s_d.data = ccpi_pkg::MASK1_VAL;
          end else begin
            s_d.cmd = ccpi_pkg::CMD_MASK2;
            s_d.data = ccpi_pkg::MASK2_VAL;
          end
        end
      end
      ST_LOW: begin
        s_d.strobe_n = 1'b1;
        s_d.st = ST_WAIT;
        s_d.cnt = s_q.cmp ? 8'(SETTLE_CYC) : 8'(FULL_CYC);
      end
      ST_WAIT: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = s_q.cnt - 8'h01;
        end else if (s_q.cmp) begin
          s_d.oe_n = 1'b0;
          s_d.hit  = ~bus.match_out_n;
          s_d.cnt  = 8'(ccpi_pkg::OE_LAT_CYC);
          s_d.st   = ST_READ;
        end else if (s_q.wr) begin
          s_d.busy = 1'b0;
          s_d.st   = ST_IDLE;
        end else begin
          s_d.step = s_q.step + 5'h01;
          s_d.st   = ST_IDLE;
          if (s_q.step == 5'(N_DEV + 6)) begin
            s_d.busy = 1'b0;
            s_d.init_done = 1'b1;
          end
        end
      end
      ST_READ: begin
        // The devices register their output enable, so the index appears a
        // cycle after oe_n falls; reading earlier would catch an idle bus.
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = s_q.cnt - 8'h01;
        end else begin
          s_d.result = bus.q;
          s_d.oe_n = 1'b1;
          s_d.busy = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.strobe_n <= 1'b1;
      s_q.oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.input_strobe_enable_n = s_q.strobe_n;
  assign bus.cmd        = s_q.cmd;
  assign bus.data       = s_q.data;
  assign bus.oe_n       = s_q.oe_n;
  assign bus.match_in_n = 1'b1;
  assign bus.full_in_n  = 1'b0;
  assign O_PRDATA       = s_q.prdata;
  assign O_PREADY       = s_q.pready;
  assign O_PSLVERR      = 1'b0;

endmodule : ccpi_ctl

// [verification/ccpi_sva.sv]
// Concurrent checks on the controller side of the cascade interface.
module ccpi_sva #(
  parameter int N_DEV = 4
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        input_strobe_enable_n,
  input  wire logic [2:0]  cmd,
  input  wire logic [31:0] data,
  input  wire logic        oe_n,
  input  wire logic        match_in_n,
  input  wire logic        full_in_n,
  input  wire logic        full_out_n
);
  localparam int SETTLE = (ccpi_pkg::SINGLE_FLAG_NS +
    (N_DEV - 1) * ccpi_pkg::STAGE_PASS_NS + ccpi_pkg::CLK_PERIOD_NS - 1) /
    ccpi_pkg::CLK_PERIOD_NS;
  logic       go;
  logic [7:0] since_cmp_q;
  logic       cfg_seen_q;
  logic       sel_seen_q;
  logic       pg_seen_q;
  logic [3:0] last_pg_q;
  assign go = !input_strobe_enable_n;
  // ****************************************************************
  // Helper state
  // ****************************************************************
  // The count saturates so that an old compare never wraps into a fresh one.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      since_cmp_q <= 8'hff;
      cfg_seen_q  <= 1'b0;
      sel_seen_q  <= 1'b0;
      pg_seen_q   <= 1'b0;
      last_pg_q   <= 4'h0;
    end else begin
      if (go && cmd == ccpi_pkg::CMD_COMPARE) since_cmp_q <= 8'h00;
      else if (since_cmp_q != 8'hff) since_cmp_q <= since_cmp_q + 8'h01;
      if (go && cmd == ccpi_pkg::CMD_CONFIG) cfg_seen_q <= 1'b1;
      if (go && cmd == ccpi_pkg::CMD_SELECT) sel_seen_q <= 1'b1;
      if (go && cmd == ccpi_pkg::CMD_PAGE_WR) begin
        pg_seen_q <= 1'b1;
        last_pg_q <= data[3:0];
      end
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RSTN);
  a_head_match_high: assert property (match_in_n)
    else $error("chain head match input not high");
  a_head_full_low: assert property (!full_in_n)
    else $error("chain head full input not low");
  a_strobe_pulse: assert property ($fell(go) |-> !go [*8])
    else $error("strobe pulses too close together");
  a_strobe_single: assert property (go |=> !go)
    else $error("strobe low for more than one cycle");
  a_oe_settle: assert property ($fell(oe_n) |->
    since_cmp_q >= 8'(SETTLE))
    else $error("output enable before chain settled");
  a_cmp_hold_oe: assert property (go && cmd == ccpi_pkg::CMD_COMPARE |=>
    oe_n [*5])
    else $error("output enable too soon after compare");
  a_page_distinct: assert property (go && cmd == ccpi_pkg::CMD_PAGE_WR &&
    pg_seen_q |-> data[3:0] != last_pg_q)
    else $error("page value repeated");
  a_mask2_value: assert property (go && cmd == ccpi_pkg::CMD_MASK2 |->
    data == ccpi_pkg::MASK2_VAL)
    else $error("second mask value wrong");
  a_config_first: assert property (go && cmd == ccpi_pkg::CMD_PAGE_WR |->
    cfg_seen_q)
    else $error("page write before common config");
  a_mask_after_sel: assert property (go && cmd == ccpi_pkg::CMD_MASK1 |->
    sel_seen_q)
    else $error("mask load before device select");
  a_ff_clear: assert property (go && cmd == ccpi_pkg::CMD_FF_CLR |->
    ##[1:16] full_out_n)
    else $error("system full not cleared");
  c_compare: cover property (go && cmd == ccpi_pkg::CMD_COMPARE);
  c_oe_fall: cover property ($fell(oe_n));
  c_ff_clear: cover property (go && cmd == ccpi_pkg::CMD_FF_CLR);
  c_nf_write: cover property (go && cmd == ccpi_pkg::CMD_NF_WRITE);
endmodule // ccpi_sva

// [verification/tb.sv]
// Testbench: controller and a chain of devices driven over APB.
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 4;
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic [31:0] rd;
  logic [N-1:0] mv_v;
  logic [N-1:0] qoe_v;
  logic [N-1:0] ten_v;
  logic [3:0]  pg_v [N];
  logic [31:0] q_v [N];
  logic [31:0] stored[$];
  int          errors;
  int          tests_run;
  int          seed;
  int          sel;
  int          en_cnt;
  logic [N-1:0] mo_v;
  ccpi_if cif();
  ccpi_if dif[N]();
  // ****************************************************************
  // Design and chain wiring
  // ****************************************************************
  ccpi_ctl #(.N_DEV(N)) ccpi_ctl_inst (.I_CORE_CLK(core_clk),
    .I_RSTN(rst_n), .bus(cif), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR());
  for (genvar g = 0; g < N; g++) begin : g_dev
    assign dif[g].input_strobe_enable_n = cif.input_strobe_enable_n;
    assign dif[g].cmd = cif.cmd;
    assign dif[g].data = cif.data;
    assign dif[g].oe_n = cif.oe_n;
    if (g == 0) begin : g_head
      assign dif[g].match_in_n = cif.match_in_n;
      assign dif[g].full_in_n = cif.full_in_n;
    end else begin : g_tail
      assign dif[g].match_in_n = &mo_v[g-1:0];
      assign dif[g].full_in_n = dif[g-1].full_out_n;
    end
    assign mv_v[g] = dif[g].match_valid_n;
    assign mo_v[g] = dif[g].match_out_n;
    assign qoe_v[g] = dif[g].q_oe;
    assign q_v[g] = dif[g].q & {32{dif[g].q_oe}};
    ccpi_dev ccpi_dev_inst (.I_CORE_CLK(core_clk), .I_RSTN(rst_n),
      .bus(dif[g]), .O_TABLE_EN(ten_v[g]), .O_PAGE(pg_v[g]));
  end
  assign cif.match_out_n = dif[N-1].match_out_n;
  assign cif.full_out_n = dif[N-1].full_out_n;
  assign cif.match_valid_n = &mv_v;
  assign cif.q_oe = |qoe_v;
  always_comb begin
    cif.q = 32'h0;
    for (int i = 0; i < N; i++) cif.q = cif.q | q_v[i];
  end
  ccpi_sva #(.N_DEV(N)) ccpi_sva_inst (.I_CORE_CLK(core_clk),
    .I_RSTN(rst_n), .input_strobe_enable_n(cif.input_strobe_enable_n),
    .cmd(cif.cmd), .data(cif.data), .oe_n(cif.oe_n),
    .match_in_n(cif.match_in_n), .full_in_n(cif.full_in_n),
    .full_out_n(cif.full_out_n));
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (pready !== 1'b1) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polling reads status repeatedly while busy, so status reads also fall inside the settling window.
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, ccpi_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (n >= 200) errors++;
  endtask
  // Model: entries fill the first device in order; lowest index wins.
  function automatic int find(input logic [31:0] k);
    int idx;
    idx = -1;
    foreach (stored[i])
      if (idx < 0 && ((stored[i] ^ k) & ~ccpi_pkg::MASK2_VAL) == 32'h0)
        idx = i;
    return idx;
  endfunction
  task automatic add_key(input logic [31:0] k);
    apb(1'b1, ccpi_pkg::REG_KEY, k);
    apb(1'b1, ccpi_pkg::REG_CTRL, 32'h4);
    wait_idle;
    stored.push_back(k);
  endtask
  task automatic cmp_key(input logic [31:0] k);
    int idx;
    idx = find(k);
    apb(1'b1, ccpi_pkg::REG_KEY, k);
    apb(1'b1, ccpi_pkg::REG_CTRL, 32'h2);
    wait_idle;
    `CHK("hit", 32'(idx >= 0) << 2, rd & 32'h4)
    `CHK("sys_match_n", idx < 0, cif.match_out_n)
    `CHK("mv_n", !(idx >= 0 && sel == 0), cif.match_valid_n)
    `CHK("q_released", 1'b0, cif.q_oe)
    if (idx >= 0) begin
      apb(1'b0, ccpi_pkg::REG_RESULT, 32'h0);
      `CHK("result", 32'(idx), rd)
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    stop_test;
  end
  initial begin
    seed = 32'he0a4;
    errors = 0;
    tests_run = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    for (int run = 0; run < 3; run++) begin
      rst_n <= 1'b0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      stored.delete();
      sel = $unsigned($random(seed)) % N;
      apb(1'b1, ccpi_pkg::REG_CTRL, (32'(sel) << 4) | 32'h1);
      apb(1'b1, ccpi_pkg::REG_CTRL, 32'h2);
      wait_idle;
      `CHK("init_done", 32'h2, rd & 32'h3)
      `CHK("sys_full_n", 1'b1, cif.full_out_n)
      en_cnt = 0;
      for (int k = 0; k < N; k++) begin
        for (int j = 0; j < k; j++)
          `CHK("page_unique", 1'b1, pg_v[k] != pg_v[j])
        `CHK("table_en", pg_v[k] === 4'(sel), ten_v[k])
        en_cnt += int'(ten_v[k] === 1'b1);
      end
      `CHK("table_count", 1, en_cnt)
      cmp_key($random(seed));
      add_key($random(seed));
      add_key($random(seed));
      cmp_key(stored[1]);
      cmp_key($random(seed));
      apb(1'b1, 8'h10, $random(seed));
      apb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 32'h0, rd)
    end
    stop_test;
  end
endmodule // tb
